// [ustx_transmitter.v]
`include "ustx_regs.vh"

module ustx_transmitter (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       cs_n,
  input  wire       ds_n,
  input  wire       rw,
  input  wire [4:0] addr,
  input  wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire       data_oe,
  output wire       dtack_n,
  output wire       dtack_oe,
  input  wire       tx_clock_in,
  input  wire       rx_clock_in,
  input  wire       serial_in,
  output wire       serial_out,
  output wire       serial_oe,
  output wire       rcv_data,
  output wire       rcv_clock,
  input  wire       rx_full,
  input  wire       rx_parity_err,
  input  wire       rx_frame_err,
  output wire       rx_ready_pin,
  output wire       tx_ready_pin,
  input  wire       irq_en_normal,
  input  wire       irq_en_error,
  output wire       tx_normal_irq,
  output wire       tx_error_irq,
  output wire       rcv_auto_enable
);

  // ===========================================================
  // Pin synchronisers.
  reg  [1:0] cs_sy_reg;
  reg  [1:0] ds_sy_reg;
  reg  [1:0] rw_sy_reg;
  reg  [4:0] ad1_reg;
  reg  [4:0] ad2_reg;
  reg  [7:0] dt1_reg;
  reg  [7:0] dt2_reg;
  reg  [2:0] tc_sy_reg;
  reg  [1:0] rr_sy_reg;

  // ===========================================================
  // Registers and sequencer state.
  reg        sel_d_reg;
  reg        wr_cyc_reg;
  reg  [4:0] wr_addr_reg;
  reg  [7:0] wr_data_reg;
  reg  [7:0] rd_data_reg;
  reg  [7:0] sync_pattern_reg;
  reg  [7:0] ctrl_reg;
  reg        tx_enable;
  reg  [1:0] mode_reg;
  reg        brk_reg;
  reg        auto_reg;
  reg        end_reg;
  reg        tx_buffer_vacant_flag;
  reg        tx_underrun_flag;
  reg        ue_lock_reg;
  reg        ue_age_reg;
  reg  [7:0] buf_reg;
  reg  [2:0] state_reg;
  reg [10:0] sh_reg;
  reg  [3:0] cnt_reg;
  reg        be_d_reg;
  reg        err_d_reg;
  reg        brk_pulse_reg;
  reg        at_pulse_reg;

  // ===========================================================
  // Bus decode from synchronised strobes.
  wire       sel      = ~cs_sy_reg[1] & ~ds_sy_reg[1];
  wire       cyc_st   = sel & ~sel_d_reg;
  wire       rd_st    = cyc_st & rw_sy_reg[1];
  wire       wr_done  = ~sel & sel_d_reg & wr_cyc_reg;
  wire       wr_sync  = wr_done & (wr_addr_reg == `USTX_ADDR_SYNC);
  wire       wr_ctrl  = wr_done & (wr_addr_reg == `USTX_ADDR_CTRL);
  wire       wr_stat  = wr_done & (wr_addr_reg == `USTX_ADDR_STAT);
  wire       wr_udr   = wr_done & (wr_addr_reg == `USTX_ADDR_DATA);
  wire       rd_stat  = rd_st & (ad2_reg == `USTX_ADDR_STAT);
  wire       tick     = tc_sy_reg[1] & ~tc_sy_reg[2];

  // ===========================================================
  // Frame geometry from the control register.
  wire [1:0] wl_code  = ctrl_reg[`USTX_CT_WL_HI:`USTX_CT_WL_LO];
  wire       par_en   = ctrl_reg[`USTX_CT_PAR];
  wire       sync_fmt = ctrl_reg[`USTX_CT_SYNC];
  wire [3:0] nbits    = `USTX_FULL_WORD - {2'h0, wl_code};
  wire [3:0] dlen     = nbits + {3'h0, par_en};
  wire [7:0] dmask    = `USTX_ONES8 >> wl_code;
  wire [8:0] smask    = `USTX_ONES9 >> ({1'b0, wl_code} + {2'h0, ~par_en});
  wire [7:0] ld_word  = (wr_udr ? wr_data_reg : buf_reg) & dmask;
  wire       ld_par   = (^ld_word) ^ ~ctrl_reg[`USTX_CT_EVEN];
  wire [8:0] dword    = {1'b0, ld_word} | ({8'h00, par_en & ld_par} << nbits);
  wire       s8par    = (^sync_pattern_reg) ^ ~ctrl_reg[`USTX_CT_EVEN];
  wire [8:0] sword    = {(nbits == `USTX_FULL_WORD) & par_en & s8par, sync_pattern_reg}; // [R19] [R20]
  wire [10:0] aframe  = ({2'h0, dword} | (11'h001 << dlen)) << 1;

  // Character end in any active state marks a boundary.
  wire       at_end   = tick & ((state_reg == `USTX_S_PRE) || (state_reg == `USTX_S_MARK) ||
                       (((state_reg == `USTX_S_SHIFT) || (state_reg == `USTX_S_BREAK)) &&
                        (cnt_reg == `USTX_ONE4)));
  wire       in_brk   = state_reg == `USTX_S_BREAK;

  // ===========================================================
  // Synchroniser flops for the bus, transmit clock and receiver status pins.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs_sy_reg <= 2'h3;
      ds_sy_reg <= 2'h3;
      rw_sy_reg <= 2'h3;
      ad1_reg   <= 5'h00;
      ad2_reg   <= 5'h00;
      dt1_reg   <= `USTX_ZERO8;
      dt2_reg   <= `USTX_ZERO8;
      tc_sy_reg <= 3'h0;
      rr_sy_reg <= 2'h0;
    end else begin
      cs_sy_reg <= {cs_sy_reg[0], cs_n};
      ds_sy_reg <= {ds_sy_reg[0], ds_n};
      rw_sy_reg <= {rw_sy_reg[0], rw};
      ad1_reg   <= addr;
      ad2_reg   <= ad1_reg;
      dt1_reg   <= data_in;
      dt2_reg   <= dt1_reg;
      tc_sy_reg <= {tc_sy_reg[1:0], tx_clock_in};
      rr_sy_reg <= {rr_sy_reg[0], rx_full & ~rx_parity_err & ~rx_frame_err};
    end
  end

  // ===========================================================
  // Bus cycle tracking and read data capture.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_d_reg   <= 1'b0;
      wr_cyc_reg  <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= `USTX_ZERO8;
      rd_data_reg <= `USTX_ZERO8;
    end else begin
      sel_d_reg <= sel;
      if (cyc_st) begin
        wr_cyc_reg <= ~rw_sy_reg[1];
      end else if (!sel) begin
        wr_cyc_reg <= 1'b0;
      end
      // Write data is taken while the strobes are still asserted.
      if (sel) begin
        wr_addr_reg <= ad2_reg;
        wr_data_reg <= dt2_reg;
      end
      if (rd_st) begin
        case (ad2_reg)
          `USTX_ADDR_SYNC: rd_data_reg <= sync_pattern_reg;
          `USTX_ADDR_CTRL: rd_data_reg <= ctrl_reg;
          `USTX_ADDR_STAT: rd_data_reg <= {tx_buffer_vacant_flag, tx_underrun_flag, auto_reg, end_reg,
                                           brk_reg, mode_reg, tx_enable};
          default:         rd_data_reg <= `USTX_ZERO8;
        endcase
      end
    end
  end

  // ===========================================================
  // Control registers, flags and the transmit sequencer.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_pattern_reg      <= `USTX_ZERO8;
      ctrl_reg              <= `USTX_CTRL_RST;
      tx_enable             <= 1'b0;
      mode_reg              <= `USTX_MODE_HIZ;
      brk_reg               <= 1'b0;
      auto_reg              <= 1'b0;
      end_reg               <= 1'b0;
      tx_buffer_vacant_flag <= 1'b1;
      tx_underrun_flag      <= 1'b0;
      ue_lock_reg           <= 1'b0;
      ue_age_reg            <= 1'b0;
      buf_reg               <= `USTX_ZERO8;
      state_reg             <= `USTX_S_IDLE;
      sh_reg                <= 11'h7ff;
      cnt_reg               <= 4'h0;
      brk_pulse_reg         <= 1'b0;
      at_pulse_reg          <= 1'b0;
    end else begin
      brk_pulse_reg <= 1'b0;
      at_pulse_reg  <= 1'b0;
      if (wr_ctrl) begin
        ctrl_reg <= wr_data_reg;
      end
      if (wr_sync) begin
        sync_pattern_reg <= wr_data_reg & smask[7:0];                 // [R18]
      end
      // Status writes: enabling restarts the sequence and clears end.
      if (wr_stat) begin
        tx_enable <= wr_data_reg[`USTX_ST_EN];
        mode_reg  <= {wr_data_reg[`USTX_ST_HIGH], wr_data_reg[`USTX_ST_LOW]};
        auto_reg  <= wr_data_reg[`USTX_ST_AUTO];
        brk_reg   <= wr_data_reg[`USTX_ST_BRK] & tx_enable;
        if (wr_data_reg[`USTX_ST_EN] && !tx_enable) begin
          end_reg <= 1'b0;                                             // [R25]
        end
        if (!wr_data_reg[`USTX_ST_EN]) begin
          tx_underrun_flag <= 1'b0;                                    // [R24]
        end
      end
      // Buffer write works whether or not the transmitter is on.
      if (wr_udr) begin
        buf_reg               <= wr_data_reg;                          // [R11]
        tx_buffer_vacant_flag <= 1'b0;                                 // [R23]
        ue_lock_reg           <= 1'b0;
      end
      // Underrun clears on a status read one transmit clock after it set.
      if (tick && tx_underrun_flag) begin
        ue_age_reg <= 1'b1;
      end
      if (rd_stat && ue_age_reg) begin
        tx_underrun_flag <= 1'b0;                                      // [R24]
        ue_age_reg       <= 1'b0;
      end
      if (tick) begin
        case (state_reg)
          `USTX_S_IDLE: begin
            if (tx_enable) begin
              state_reg <= `USTX_S_PRE;                                // [R6]
            end else if (!(wr_stat && wr_data_reg[`USTX_ST_EN])) begin
              end_reg <= 1'b1;                                         // [R25]
            end
          end
          `USTX_S_SHIFT: begin
            sh_reg  <= {1'b1, sh_reg[10:1]};
            cnt_reg <= cnt_reg - `USTX_ONE4;
          end
          `USTX_S_BREAK: begin
            cnt_reg <= cnt_reg - `USTX_ONE4;
          end
          default: begin
            cnt_reg <= cnt_reg;
          end
        endcase
      end
      // Character boundary: choose what goes out next.
      if (at_end) begin
        if (in_brk && !tx_underrun_flag) begin
          brk_pulse_reg <= 1'b1;                                       // [R14] [R15]
        end
        if (!tx_enable) begin
          state_reg    <= `USTX_S_IDLE;                                // [R5] [R12] [R13]
          end_reg      <= 1'b1;                                        // [R25]
          at_pulse_reg <= auto_reg;
        end else if (brk_reg && !sync_fmt) begin
          state_reg <= `USTX_S_BREAK;                                  // [R26]
          cnt_reg   <= dlen + 4'h2;
        end else if (!tx_buffer_vacant_flag || wr_udr) begin
          state_reg             <= `USTX_S_SHIFT;
          tx_buffer_vacant_flag <= 1'b1;                               // [R23]
          sh_reg                <= sync_fmt ? {2'h3, dword} : aframe;
          cnt_reg               <= sync_fmt ? dlen : dlen + 4'h2;
        end else begin
          if (!ue_lock_reg) begin
            tx_underrun_flag <= 1'b1;                                  // [R24]
            ue_lock_reg      <= 1'b1;
            ue_age_reg       <= 1'b0;
          end
          if (sync_fmt) begin
            state_reg <= `USTX_S_SHIFT;                                // [R9]
            sh_reg    <= {2'h3, sword};
            cnt_reg   <= dlen;
          end else begin
            state_reg <= `USTX_S_MARK;                                 // [R10]
          end
        end
      end
    end
  end

  // ===========================================================
  // Interrupt edge detection on the flag outputs.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      be_d_reg  <= 1'b1;
      err_d_reg <= 1'b0;
    end else begin
      be_d_reg  <= tx_buffer_vacant_flag;                              // [R16]
      err_d_reg <= tx_underrun_flag | end_reg;
    end
  end

  // Channels see rising flag edges, and the error channel break pulses, while enabled.
  assign tx_normal_irq   = irq_en_normal & tx_buffer_vacant_flag & ~be_d_reg;                 // [R8] [R17]
  assign tx_error_irq    = irq_en_error & (((tx_underrun_flag | end_reg) & ~err_d_reg) |
                                           brk_pulse_reg);                                     // [R8] [R17]
  assign rcv_auto_enable = at_pulse_reg;

  // ===========================================================
  // Line driver: idle level follows the output mode.
  wire idle_st = state_reg == `USTX_S_IDLE;
  wire loop    = mode_reg == `USTX_MODE_LOOP;
  assign serial_out = idle_st ? (mode_reg != `USTX_MODE_LOW) :                                 // [R1] [R2] [R3]
                      in_brk ? 1'b0 :
                      (state_reg == `USTX_S_SHIFT) ? sh_reg[0] : 1'b1;
  assign serial_oe  = (idle_st || (state_reg == `USTX_S_PRE)) ?
                      (mode_reg != `USTX_MODE_HIZ) : 1'b1;                                      // [R1] [R4]

  // Loop-back bypasses the external receive pins.
  assign rcv_data  = loop ? serial_out : serial_in;                                             // [R2]
  assign rcv_clock = loop ? tx_clock_in : rx_clock_in;                                          // [R2]

  // ===========================================================
  // Handshake pins and bus outputs.
  assign rx_ready_pin = rr_sy_reg[1];                                                           // [R21]
  assign tx_ready_pin = tx_buffer_vacant_flag & ~in_brk;                                        // [R22]
  assign data_out     = rd_data_reg;
  assign data_oe      = sel & sel_d_reg & rw_sy_reg[1];
  assign dtack_n      = ~(sel & sel_d_reg);
  assign dtack_oe     = sel;

endmodule

// [ustx_regs.vh]
`ifndef USTX_REGS_VH
`define USTX_REGS_VH
// Contract
// R1: Output-mode bits set pin while transmitter off.
// R2: Loop-back routes data and clock internally.
// R3: Mode bits steer line until transmitter starts.
// R4: High-impedance mode leaves first bit undriven.
// R5: Disable finishes current word; break stops unterminated.
// R6: One mark bit precedes first word.
// R7: Clock running and mode set before enable.
// R8: Empty channel, and underrun-or-end channel.
// R9: Synchronous underrun repeats the sync character.
// R10: Asynchronous underrun holds the line at mark.
// R11: Buffer accepts data while transmitter is disabled.
// R12: Disable leaves buffered word and empty flag alone.
// R13: No underrun after disable mid-character.
// R14: Break raises error pulse each character time.
// R15: Software clears underrun before break pulses appear.
// R16: Flags update regardless of channel enables.
// R17: Interrupt channels fire only on flag edges; the error channel also fires on break pulses.
// R18: Sync write zeroes bits beyond word length.
// R19: Short sync word carries its own parity bit.
// R20: Eight-bit sync word gets computed parity.
// R21: Receiver ready follows full without errors.
// R22: Transmitter ready follows empty outside break.
// R23: Empty flag sets on load, clears on write.
// R24: Underrun sets once; read clears after a clock.
// R25: End flag sets after drain, clears on enable.
// R26: Break waits for character, blocks empty flag.

// ===========================================================
// Register addresses on the five address pins.
`define USTX_ADDR_SYNC    5'h13
`define USTX_ADDR_CTRL    5'h14
`define USTX_ADDR_STAT    5'h15
`define USTX_ADDR_DATA    5'h17

// ===========================================================
// Transmitter status register bit positions.
`define USTX_ST_EN        0
`define USTX_ST_LOW       1
`define USTX_ST_HIGH      2
`define USTX_ST_BRK       3
`define USTX_ST_END       4
`define USTX_ST_AUTO      5
`define USTX_ST_UNDER     6
`define USTX_ST_EMPTY     7

// ===========================================================
// Control register fields.
`define USTX_CT_EVEN      1
`define USTX_CT_PAR       2
`define USTX_CT_SYNC      3
`define USTX_CT_WL_LO     5
`define USTX_CT_WL_HI     6

// ===========================================================
// Output modes and constants.
`define USTX_MODE_HIZ     2'h0
`define USTX_MODE_LOW     2'h1
`define USTX_MODE_LOOP    2'h3
`define USTX_FULL_WORD    4'h8
`define USTX_ONE4         4'h1
`define USTX_ZERO8        8'h00
`define USTX_ONES8        8'hff
`define USTX_ONES9        9'h1ff
`define USTX_CTRL_RST     8'h00

// ===========================================================
// Sequencer states.
`define USTX_S_IDLE       3'h0
`define USTX_S_PRE        3'h1
`define USTX_S_SHIFT      3'h2
`define USTX_S_MARK       3'h3
`define USTX_S_BREAK      3'h4
`endif

// [ustx_monitor.sv]
module ustx_monitor (
  input wire       sys_clk,
  input wire       rstn,
  input wire       cs_n,
  input wire       ds_n,
  input wire       dtack_n,
  input wire       dtack_oe,
  input wire       tx_clock_in,
  input wire       serial_in,
  input wire       serial_out,
  input wire       rcv_data,
  input wire       rx_full,
  input wire       rx_parity_err,
  input wire       rx_frame_err,
  input wire       rx_ready_pin,
  input wire       irq_en_normal,
  input wire       irq_en_error,
  input wire       tx_normal_irq,
  input wire       tx_error_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ===========================================================
  // Port relations, all in the system clock domain.
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Bus acknowledge arrives a few cycles after the strobe and drops after release.
  a_ack_delay: assert property ($fell(ds_n) && !cs_n |-> dtack_n ##[1:5] !dtack_n)
    else $error("acknowledge late or early");
  a_ack_release: assert property (!dtack_n && $rose(cs_n) |-> ##[1:4] dtack_n)
    else $error("acknowledge held after release");
  a_ack_drive: assert property (!dtack_n |-> dtack_oe)
    else $error("acknowledge low while undriven");
  // Interrupt channels pulse for one cycle and only while enabled.
  a_norm_pulse: assert property (tx_normal_irq |=> !tx_normal_irq)
    else $error("normal interrupt longer than one cycle");
  a_norm_gated: assert property (tx_normal_irq |-> irq_en_normal || $past(irq_en_normal))
    else $error("normal interrupt while channel disabled");
  a_err_pulse: assert property (tx_error_irq |=> !tx_error_irq)
    else $error("error interrupt longer than one cycle");
  a_err_gated: assert property (tx_error_irq |-> irq_en_error || $past(irq_en_error))
    else $error("error interrupt while channel disabled");
  // Receiver ready follows full and error inputs within the synchronizer delay.
  a_rdy_set: assert property ((rx_full && !rx_parity_err && !rx_frame_err) [*4] |-> rx_ready_pin)
    else $error("receiver ready missing");
  a_rdy_clear: assert property ((!rx_full || rx_parity_err || rx_frame_err) [*4] |-> !rx_ready_pin)
    else $error("receiver ready while not full or in error");
  // Receive data comes either from the pin or from the loop-back path.
  a_rcv_route: assert property (rcv_data == serial_in || rcv_data == serial_out ||
    rcv_data == $past(serial_in) || rcv_data == $past(serial_out))
    else $error("receive data from unknown source");
  // The line moves only after a bit clock edge or a register write.
  a_line_steps: assert property ($changed(serial_out) |-> $past(tx_clock_in, 2) ||
    $past(tx_clock_in, 3) || !$past(ds_n, 3) || !$past(ds_n, 4))
    else $error("line changed without bit clock");
endmodule

bind ustx_transmitter ustx_monitor u_mon (.sys_clk, .rstn, .cs_n, .ds_n, .dtack_n, .dtack_oe,
  .tx_clock_in, .serial_in, .serial_out, .rcv_data, .rx_full, .rx_parity_err, .rx_frame_err,
  .rx_ready_pin, .irq_en_normal, .irq_en_error, .tx_normal_irq, .tx_error_irq);

// [ustx_far_end.sv]
module ustx_far_end (
  input  wire       sys_clk,
  input  wire       serial_out,
  input  wire       serial_oe,
  output reg        tx_clock_in,
  output reg        rx_clock_in,
  output reg        serial_in,
  output reg  [7:0] got_byte,
  output reg        got_stop,
  output reg  [7:0] got_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  reg   [2:0] div = 3'h0;
  reg   [3:0] bit_n = 4'h0;
  reg   [7:0] sh = 8'h00;
  reg         held = 1'b1;
  wire        line = serial_oe ? serial_out : ~held;
  initial begin
    tx_clock_in = 1'b0;
    rx_clock_in = 1'b0;
    serial_in = 1'b0;
    got_byte = 8'h00;
    got_stop = 1'b0;
    got_cnt = 8'h00;
  end
  // Free-running bit clock of eight system cycles, and busy receive pins.
  always @(posedge sys_clk) begin
    #5;
    div = div + 3'h1;
    tx_clock_in = div[2];
    rx_clock_in = div[1];
    serial_in = ~serial_in;
    if (serial_oe) held = serial_out;
  end
  // Asynchronous receiver sampling the line on each falling edge of the bit clock.
  always @(negedge tx_clock_in) begin
    if (bit_n == 4'h0) begin
      if (!line) bit_n <= 4'h1;
    end else if (bit_n < 4'h9) begin
      sh <= {line, sh[7:1]};
      bit_n <= bit_n + 4'h1;
    end else begin
      got_byte <= sh;
      got_stop <= line;
      got_cnt <= got_cnt + 8'h01;
      bit_n <= 4'h0;
    end
  end
endmodule

// [usart_transmit_section_tb.sv]
`include "ustx_regs.vh"
module usart_transmit_section_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg        sys_clk = 1'b0;
  reg        rstn = 1'b0;
  reg        cs_n = 1'b1;
  reg        ds_n = 1'b1;
  reg        rw = 1'b1;
  reg  [4:0] addr = 5'h00;
  reg  [7:0] data_in = 8'h00;
  reg        rx_full = 1'b0;
  reg        rx_parity_err = 1'b0;
  reg        rx_frame_err = 1'b0;
  reg        irq_en_normal = 1'b0;
  reg        irq_en_error = 1'b0;
  reg  [7:0] rd;
  reg        lo;
  integer    err_count = 0;
  integer    n_tests = 0;
  integer    n_norm = 0;
  integer    n_err = 0;
  integer    n_auto = 0;
  integer    cyc = 0;
  integer    k;
  wire [7:0] data_out, got_byte, got_cnt;
  wire       data_oe, dtack_n, dtack_oe, tx_clock_in, rx_clock_in, serial_in, serial_out, serial_oe;
  wire       rcv_data, rcv_clock, rx_ready_pin, tx_ready_pin, tx_normal_irq, tx_error_irq;
  wire       rcv_auto_enable, got_stop;

  ustx_transmitter u_dut (.sys_clk, .rstn, .cs_n, .ds_n, .rw, .addr, .data_in, .data_out, .data_oe,
    .dtack_n, .dtack_oe, .tx_clock_in, .rx_clock_in, .serial_in, .serial_out, .serial_oe, .rcv_data,
    .rcv_clock, .rx_full, .rx_parity_err, .rx_frame_err, .rx_ready_pin, .tx_ready_pin, .irq_en_normal,
    .irq_en_error, .tx_normal_irq, .tx_error_irq, .rcv_auto_enable);
  ustx_far_end u_far (.sys_clk, .serial_out, .serial_oe, .tx_clock_in, .rx_clock_in, .serial_in,
    .got_byte, .got_stop, .got_cnt);

  // ===========================================================
  // Clock, interrupt pulse counting and hang guard.
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (tx_normal_irq === 1'b1) n_norm = n_norm + 1;
    if (tx_error_irq === 1'b1) n_err = n_err + 1;
    if (rcv_auto_enable === 1'b1) n_auto = n_auto + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end

  // ===========================================================
  // Shared checking and bus tasks.
  task print_verdict;
    begin
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Holds the cycle until acknowledge is sampled low, then releases.
  task bus(input r, input [4:0] a, input [7:0] d);
    integer i;
    begin
      @(posedge sys_clk);
      #5;
      rw = r;
      addr = a;
      data_in = d;
      cs_n = 1'b0;
      ds_n = 1'b0;
      for (i = 0; i < 12 && dtack_n !== 1'b0; i = i + 1) @(negedge sys_clk);
      rd = data_out;
      chk({7'h00, dtack_n}, 8'h00);
      chk({7'h00, data_oe}, {7'h00, r});
      @(posedge sys_clk);
      #5;
      cs_n = 1'b1;
      ds_n = 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task rdc(input [4:0] a, input [7:0] m, input [7:0] e);
    begin
      bus(1'b1, a, 8'h00);
      chk(rd & m, e);
    end
  endtask
  task wait_byte(input [7:0] e);
    reg [7:0] c0;
    integer i;
    begin
      c0 = got_cnt;
      for (i = 0; i < 400 && got_cnt === c0; i = i + 1) @(posedge sys_clk);
      chk(got_byte, e);
      chk({7'h00, got_stop}, 8'h01);
    end
  endtask

  // ===========================================================
  // Scenarios.
  task t_reset;
    begin
      chk({7'h00, serial_oe}, 8'h00);
      chk({7'h00, tx_ready_pin}, 8'h01);
      rdc(`USTX_ADDR_STAT, 8'hc9, 8'h80);
      rdc(`USTX_ADDR_DATA, 8'hff, 8'h00);
      rdc(5'h00, 8'hff, 8'h00);
    end
  endtask
  task t_modes;
    integer m;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        bus(1'b0, `USTX_ADDR_STAT, {m[6:0], 1'b0});
        repeat (3) @(posedge sys_clk);
        chk({7'h00, serial_oe}, {7'h00, m != 0});
        if (m != 0) chk({7'h00, serial_out}, {7'h00, m != 1});
      end
      chk({7'h00, rcv_data}, {7'h00, serial_out});
      chk({7'h00, rcv_clock}, {7'h00, tx_clock_in});
      bus(1'b0, `USTX_ADDR_STAT, 8'h04);
    end
  endtask
  task t_sync;
    begin
      bus(1'b0, `USTX_ADDR_CTRL, 8'h60);
      bus(1'b0, `USTX_ADDR_SYNC, 8'hff);
      rdc(`USTX_ADDR_SYNC, 8'hff, 8'h1f);
      bus(1'b0, `USTX_ADDR_CTRL, 8'h64);
      bus(1'b0, `USTX_ADDR_SYNC, 8'hff);
      rdc(`USTX_ADDR_SYNC, 8'hff, 8'h3f);
      bus(1'b0, `USTX_ADDR_CTRL, 8'h00);
      bus(1'b0, `USTX_ADDR_SYNC, 8'hff);
      rdc(`USTX_ADDR_SYNC, 8'hff, 8'hff);
    end
  endtask
  task t_frame;
    begin
      #5;
      irq_en_normal = 1'b1;
      irq_en_error = 1'b1;
      bus(1'b0, `USTX_ADDR_DATA, 8'ha5);
      rdc(`USTX_ADDR_STAT, 8'h80, 8'h00);
      chk({7'h00, tx_ready_pin}, 8'h00);
      k = n_norm;
      bus(1'b0, `USTX_ADDR_STAT, 8'h05);
      wait_byte(8'ha5);
      chk({7'h00, n_norm > k}, 8'h01);
      k = n_err;
      lo = 1'b0;
      repeat (200) @(posedge sys_clk) lo = lo | ~serial_out;
      chk({7'h00, lo}, 8'h00);
      chk({7'h00, n_err > k}, 8'h01);
      rdc(`USTX_ADDR_STAT, 8'hc0, 8'hc0);
      rdc(`USTX_ADDR_STAT, 8'h40, 8'h00);
    end
  endtask
  task t_edge;
    begin
      #5;
      irq_en_normal = 1'b0;
      k = n_norm;
      bus(1'b0, `USTX_ADDR_DATA, 8'h3c);
      wait_byte(8'h3c);
      irq_en_normal = 1'b1;
      repeat (20) @(posedge sys_clk);
      chk({7'h00, n_norm == k}, 8'h01);
      rdc(`USTX_ADDR_STAT, 8'h80, 8'h80);
    end
  endtask
  task t_break;
    begin
      bus(1'b1, `USTX_ADDR_STAT, 8'h00);
      k = n_err;
      bus(1'b0, `USTX_ADDR_STAT, 8'h0d);
      repeat (300) @(posedge sys_clk);
      chk({7'h00, serial_out}, 8'h00);
      chk({7'h00, tx_ready_pin}, 8'h00);
      chk({7'h00, n_err >= k + 2}, 8'h01);
      bus(1'b0, `USTX_ADDR_STAT, 8'h04);
      repeat (300) @(posedge sys_clk);
      rdc(`USTX_ADDR_STAT, 8'h11, 8'h10);
      chk({7'h00, serial_out}, 8'h01);
    end
  endtask
  task t_mid;
    begin
      bus(1'b0, `USTX_ADDR_STAT, 8'h05);
      rdc(`USTX_ADDR_STAT, 8'h10, 8'h00);
      bus(1'b0, `USTX_ADDR_DATA, 8'h42);
      repeat (40) @(posedge sys_clk);
      k = n_auto;
      bus(1'b0, `USTX_ADDR_STAT, 8'h24);
      wait_byte(8'h42);
      repeat (100) @(posedge sys_clk);
      rdc(`USTX_ADDR_STAT, 8'h50, 8'h10);
      chk({7'h00, n_auto == k + 1}, 8'h01);
    end
  endtask
  // Synchronous underrun: the sync word with odd parity repeats every nine bits.
  task t_synctx;
    reg [26:0] s;
    integer i;
    begin
      bus(1'b0, `USTX_ADDR_CTRL, 8'h0c);
      bus(1'b0, `USTX_ADDR_SYNC, 8'h96);
      bus(1'b0, `USTX_ADDR_STAT, 8'h05);
      repeat (40) @(negedge tx_clock_in);
      for (i = 0; i < 27; i = i + 1) @(negedge tx_clock_in) s = {serial_out, s[26:1]};
      chk({7'h00, ^s[8:0]}, 8'h01);
      chk({7'h00, |(s[26:9] ^ s[17:0])}, 8'h00);
    end
  endtask
  task t_rx;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        #5;
        {rx_full, rx_parity_err, rx_frame_err} = i[2:0];
        repeat (4) @(posedge sys_clk);
        chk({7'h00, rx_ready_pin}, {7'h00, i == 4});
      end
    end
  endtask

  // ===========================================================
  // Main sequence.
  initial begin
    repeat (16) @(posedge sys_clk);
    #5;
    rstn = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_modes;
    t_sync;
    t_frame;
    t_edge;
    t_break;
    t_mid;
    t_synctx;
    t_rx;
    print_verdict;
  end
endmodule
